// *** src/dst_regs.svh ***
// fixed dates, hours and shift amounts of the summertime schedules
`ifndef DST_REGS_SVH
`define DST_REGS_SVH
`define DST_MARCH 4'h3
`define DST_APRIL 4'h4
`define DST_OCTOBER 4'hA
`define DST_NOVEMBER 4'hB
`define DST_HOUR_1 5'h01
`define DST_HOUR_2 5'h02
`define DST_HOUR_3 5'h03
`define DST_ORD_LAST 2'h0
`define DST_ORD_FIRST 2'h1
`define DST_ORD_SECOND 2'h2
`define DST_ORD_THIRD 2'h3
`define DST_PRESET_SHIFT 8'h3C
`define DST_OFFSET_MAX 8'hB4
`define DST_OFFSET_RST 8'h00
`define DST_MIN_PER_HOUR 11'h03C
`define DST_DAYS_LONG 5'h1F
`define DST_DAYS_SHORT 5'h1E
`define DST_DAYS_FEB 5'h1C
`endif

// *** src/dst_pkg.sv ***
// types shared by the summertime conversion block
package dst_pkg;
    typedef enum logic [2:0] {
        europe_schedule = 3'h0,
        britain_schedule = 3'h1,
        america_legacy_schedule = 3'h2,
        america_current_schedule = 3'h3,
        australia_schedule = 3'h4,
        tasmania_schedule = 3'h5,
        new_zealand_schedule = 3'h6,
        custom_schedule = 3'h7
    } dst_sched_t;

    typedef enum logic [2:0] {
        st_idle = 3'b001,
        st_load = 3'b010,
        st_send = 3'b100
    } dst_state_t;
endpackage

// *** src/dst_sunday_hit.sv ***
// detects the nth or last sunday of a given month
`timescale 1ns/1ps
`include "dst_regs.svh"
module dst_sunday_hit (
    input wire logic [3:0] month_in,
    input wire logic [4:0] day_in,
    input wire logic [2:0] wday_in,
    input wire logic [3:0] want_month_in,
    input wire logic [1:0] ordinal_in,
    output logic hit_out
);
    // february counted as 28 days: no schedule uses it
    function automatic logic [4:0] days_in_month(input logic [3:0] m);
        case (m)
            4'h2: days_in_month = `DST_DAYS_FEB;
            4'h4, 4'h6, 4'h9, 4'hB: days_in_month = `DST_DAYS_SHORT;
            default: days_in_month = `DST_DAYS_LONG;
        endcase
    endfunction

    wire logic sunday;
    wire logic is_last;
    wire logic [4:0] week_idx;
    wire logic is_nth;

    assign sunday = (wday_in == 3'h0) && (month_in == want_month_in);
    assign is_last = ({1'b0, day_in} + 6'h07) > {1'b0, days_in_month(month_in)}; // R19
    assign week_idx = (day_in - 5'h01) / 5'h07;
    assign is_nth = (week_idx[1:0] + 2'h1 == ordinal_in) && (week_idx < 5'h03); // R19
    assign hit_out = sunday && ((ordinal_in == `DST_ORD_LAST) ? is_last : is_nth);
endmodule

// *** src/dst_conv.sv ***
// summertime conversion, clock sync and time distribution
`timescale 1ns/1ps
`include "dst_regs.svh"

// Behaviour
// [R1] europe: march last sun 2->3, october 3->2
// [R2] britain: march last sun 1->2, october 2->1
// [R3] legacy america: april first, october last
// [R4] current america: march second, november first
// [R5] australia: october last forward, march last back
// [R6] tasmania: october first forward, march last back
// [R7] new zealand: october first, march third back
// [R8] presets shift sixty minutes each way
// [R9] custom: add at 02:00, subtract at 03:00
// [R10] custom offset 0 to 180 minutes
// [R11] transitions only while mains powered
// [R12] sync enabled: load bus time into clock
// [R13] send time at power-up and hourly
// [R14] send time after manual set or shift
// [R15] sync enable resets to disabled
// [R16] far side: no sync without bus module
// [R17] conversion resets disabled; disabled means no shift
// [R18] each shift applied once per date
// [R19] nth or last sunday from date, weekday
module dst_conv (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic ce_in,
    input wire logic powered_in,
    input wire logic cfg_write_in,
    input wire logic cfg_dst_en_in,
    input wire logic cfg_sync_en_in,
    input wire dst_pkg::dst_sched_t cfg_sched_in,
    input wire logic [3:0] cfg_start_month_in,
    input wire logic [4:0] cfg_start_day_in,
    input wire logic [3:0] cfg_end_month_in,
    input wire logic [4:0] cfg_end_day_in,
    input wire logic [7:0] cfg_offset_in,
    input wire logic [3:0] rtc_month_in,
    input wire logic [4:0] rtc_day_in,
    input wire logic [2:0] rtc_wday_in,
    input wire logic [4:0] rtc_hour_in,
    input wire logic [5:0] rtc_minute_in,
    input wire logic rtc_minute_tick_in,
    input wire logic manual_set_in,
    input wire logic bus_time_valid_in,
    input wire logic [4:0] bus_hour_in,
    input wire logic [5:0] bus_minute_in,
    output logic rtc_load_out,
    output logic tx_req_out,
    output logic [4:0] time_hour_out,
    output logic [5:0] time_minute_out,
    output logic summer_out,
    output logic cfg_reject_out
);
    import dst_pkg::*;

    // ----------------------------------------
    // schedule table
    // ----------------------------------------
    // {start month, start ordinal, start hour, end month, end ordinal, end hour}
    function automatic logic [21:0] sched_rule(input dst_sched_t s);
        case (s)
            europe_schedule: sched_rule = {`DST_MARCH, `DST_ORD_LAST, `DST_HOUR_2,
                `DST_OCTOBER, `DST_ORD_LAST, `DST_HOUR_3}; // R1
            britain_schedule: sched_rule = {`DST_MARCH, `DST_ORD_LAST, `DST_HOUR_1,
                `DST_OCTOBER, `DST_ORD_LAST, `DST_HOUR_2}; // R2
            america_legacy_schedule: sched_rule = {`DST_APRIL, `DST_ORD_FIRST, `DST_HOUR_2,
                `DST_OCTOBER, `DST_ORD_LAST, `DST_HOUR_2}; // R3
            america_current_schedule: sched_rule = {`DST_MARCH, `DST_ORD_SECOND, `DST_HOUR_2,
                `DST_NOVEMBER, `DST_ORD_FIRST, `DST_HOUR_2}; // R4
            australia_schedule: sched_rule = {`DST_OCTOBER, `DST_ORD_LAST, `DST_HOUR_2,
                `DST_MARCH, `DST_ORD_LAST, `DST_HOUR_3}; // R5
            tasmania_schedule: sched_rule = {`DST_OCTOBER, `DST_ORD_FIRST, `DST_HOUR_2,
                `DST_MARCH, `DST_ORD_LAST, `DST_HOUR_3}; // R6
            new_zealand_schedule: sched_rule = {`DST_OCTOBER, `DST_ORD_FIRST, `DST_HOUR_2,
                `DST_MARCH, `DST_ORD_THIRD, `DST_HOUR_3}; // R7
            default: sched_rule = {4'h0, `DST_ORD_LAST, `DST_HOUR_2,
                4'h0, `DST_ORD_LAST, `DST_HOUR_3}; // R9
        endcase
    endfunction

    // ----------------------------------------
    // state
    // ----------------------------------------
    logic pwr_s1_ff, pwr_ff, pwr_d_ff;
    logic dst_en_ff, sync_en_ff;
    dst_sched_t sched_ff;
    logic [3:0] cs_month_ff, ce_month_ff;
    logic [4:0] cs_day_ff, ce_day_ff;
    logic [7:0] offset_ff;
    logic summer_ff, pend_hour_ff, pend_tx_ff, pend_sync_ff;
    logic [4:0] bus_hour_ff, hour_ff;
    logic [5:0] bus_minute_ff, minute_ff;
    logic load_ff, tx_ff, reject_ff;
    dst_state_t state_ff, nxt_state;

    wire logic [21:0] rule;
    wire logic start_sun, end_sun, start_date, end_date, is_custom;
    wire logic at_hour, fwd_fire, bwd_fire, shift_fire, sync_fire, idle;
    wire logic hour_mark, offset_ok;
    wire logic [7:0] shift_amt;
    wire logic [10:0] cur_min, new_min;
    wire logic [4:0] nxt_hour;
    wire logic [5:0] nxt_minute;

    assign rule = sched_rule(sched_ff);
    assign is_custom = (sched_ff == custom_schedule);
    assign idle = (state_ff == st_idle);

    dst_sunday_hit u_start (
        .month_in(rtc_month_in),
        .day_in(rtc_day_in),
        .wday_in(rtc_wday_in),
        .want_month_in(rule[21:18]),
        .ordinal_in(rule[17:16]),
        .hit_out(start_sun)
    );

    dst_sunday_hit u_end (
        .month_in(rtc_month_in),
        .day_in(rtc_day_in),
        .wday_in(rtc_wday_in),
        .want_month_in(rule[10:7]),
        .ordinal_in(rule[6:5]),
        .hit_out(end_sun)
    );

    // ----------------------------------------
    // transition decode
    // ----------------------------------------
    assign start_date = is_custom ? (rtc_month_in == cs_month_ff && rtc_day_in == cs_day_ff)
                                  : start_sun; // R9
    assign end_date = is_custom ? (rtc_month_in == ce_month_ff && rtc_day_in == ce_day_ff)
                                : end_sun; // R9
    assign at_hour = idle && pend_hour_ff && (rtc_minute_in == 6'h00);
    // summer flag gates each direction so a repeated hour cannot fire twice
    assign fwd_fire = at_hour && dst_en_ff && pwr_ff && !summer_ff && start_date
        && (rtc_hour_in == rule[15:11]); // R11 R17 R18
    assign bwd_fire = at_hour && dst_en_ff && pwr_ff && summer_ff && end_date
        && (rtc_hour_in == rule[4:0]); // R11 R17 R18
    assign shift_fire = fwd_fire || bwd_fire;
    assign sync_fire = idle && pend_sync_ff && !shift_fire;
    assign shift_amt = is_custom ? offset_ff : `DST_PRESET_SHIFT; // R8
    assign cur_min = 11'(rtc_hour_in) * `DST_MIN_PER_HOUR + 11'(rtc_minute_in);
    assign new_min = fwd_fire ? cur_min + 11'(shift_amt) : cur_min - 11'(shift_amt);
    assign nxt_hour = shift_fire ? 5'(new_min / `DST_MIN_PER_HOUR)
                    : sync_fire ? bus_hour_ff : rtc_hour_in;
    assign nxt_minute = shift_fire ? 6'(new_min % `DST_MIN_PER_HOUR)
                      : sync_fire ? bus_minute_ff : rtc_minute_in;
    assign hour_mark = rtc_minute_tick_in && (rtc_minute_in == 6'h00) && pwr_ff;
    assign offset_ok = (cfg_offset_in <= `DST_OFFSET_MAX);

    always_comb begin
        case (state_ff)
            st_idle: begin
                if (shift_fire || sync_fire) begin
                    nxt_state = st_load;
                end else if (pend_hour_ff || pend_tx_ff) begin
                    nxt_state = st_send;
                end else begin
                    nxt_state = st_idle;
                end
            end
            st_load: nxt_state = st_send; // R14
            st_send: nxt_state = st_idle;
            default: nxt_state = st_idle;
        endcase
    end

    // ----------------------------------------
    // power sense and configuration
    // ----------------------------------------
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pwr_s1_ff <= 1'b0;
            pwr_ff <= 1'b0;
            pwr_d_ff <= 1'b0;
        end else if (ce_in) begin
            pwr_s1_ff <= powered_in;
            pwr_ff <= pwr_s1_ff;
            pwr_d_ff <= pwr_ff;
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            dst_en_ff <= 1'b0; // R17
            sync_en_ff <= 1'b0; // R15
            sched_ff <= europe_schedule;
            cs_month_ff <= 4'h0;
            cs_day_ff <= 5'h00;
            ce_month_ff <= 4'h0;
            ce_day_ff <= 5'h00;
            offset_ff <= `DST_OFFSET_RST;
            reject_ff <= 1'b0;
        end else if (ce_in) begin
            reject_ff <= cfg_write_in && !offset_ok;
            if (cfg_write_in) begin
                dst_en_ff <= cfg_dst_en_in;
                sync_en_ff <= cfg_sync_en_in;
                sched_ff <= cfg_sched_in;
                cs_month_ff <= cfg_start_month_in;
                cs_day_ff <= cfg_start_day_in;
                ce_month_ff <= cfg_end_month_in;
                ce_day_ff <= cfg_end_day_in;
                if (offset_ok) begin
                    offset_ff <= cfg_offset_in; // R10
                end
            end
        end
    end

    // ----------------------------------------
    // pending events and sequencer
    // ----------------------------------------
    // a new event in the clearing cycle stays pending
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            pend_hour_ff <= 1'b0;
            pend_tx_ff <= 1'b0;
            pend_sync_ff <= 1'b0;
            bus_hour_ff <= 5'h00;
            bus_minute_ff <= 6'h00;
        end else if (ce_in) begin
            pend_hour_ff <= hour_mark || (pend_hour_ff && !(idle && nxt_state != st_idle)); // R13
            pend_tx_ff <= manual_set_in || (pwr_ff && !pwr_d_ff)
                || (pend_tx_ff && !(idle && nxt_state != st_idle)); // R13 R14
            pend_sync_ff <= (bus_time_valid_in && sync_en_ff) || (pend_sync_ff && !sync_fire);
            if (bus_time_valid_in && sync_en_ff) begin
                bus_hour_ff <= bus_hour_in; // R12
                bus_minute_ff <= bus_minute_in; // R12
            end
        end
    end

    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            state_ff <= st_idle;
            summer_ff <= 1'b0;
            hour_ff <= 5'h00;
            minute_ff <= 6'h00;
            load_ff <= 1'b0;
            tx_ff <= 1'b0;
        end else if (ce_in) begin
            state_ff <= nxt_state;
            load_ff <= (nxt_state == st_load);
            tx_ff <= (nxt_state == st_send); // R13 R14
            if (fwd_fire) begin
                summer_ff <= 1'b1; // R18
            end else if (bwd_fire || !dst_en_ff) begin
                summer_ff <= 1'b0;
            end
            if (idle) begin
                hour_ff <= nxt_hour;
                minute_ff <= nxt_minute;
            end
        end
    end

    assign rtc_load_out = load_ff;
    assign tx_req_out = tx_ff;
    assign time_hour_out = hour_ff;
    assign time_minute_out = minute_ff;
    assign summer_out = summer_ff;
    assign cfg_reject_out = reject_ff;

    // ----------------------------------------
    // checks
    // ----------------------------------------
    a_load_then_send: assert property (@(posedge clock_in) disable iff (!rstn_in) // R14
        rtc_load_out && ce_in |=> tx_req_out) else $error("load not followed by send");
    a_shift_needs_en: assert property (@(posedge clock_in) disable iff (!rstn_in) // R17
        !dst_en_ff && ce_in |=> !summer_out) else $error("summertime kept while disabled");
    a_shift_needs_pwr: assert property (@(posedge clock_in) disable iff (!rstn_in) // R11
        !pwr_ff && dst_en_ff && ce_in |=> $stable(summer_out)) else $error("shift on backup");
    a_offset_range: assert property (@(posedge clock_in) disable iff (!rstn_in) // R10
        offset_ff <= `DST_OFFSET_MAX) else $error("offset above limit");
    a_sync_loads: assert property (@(posedge clock_in) disable iff (!rstn_in) // R12
        sync_fire && ce_in |=> rtc_load_out && time_hour_out == $past(bus_hour_ff))
        else $error("sync time not loaded");
    a_hour_sends: assert property (@(posedge clock_in) disable iff (!rstn_in || !ce_in) // R13
        idle && pend_hour_ff |=> ##[0:1] tx_req_out) else $error("hourly send missing");
    a_summer_cause: assert property (@(posedge clock_in) disable iff (!rstn_in) // R18
        $rose(summer_ff) |-> $past(fwd_fire)) else $error("summer set without forward shift");
    a_preset_step: assert property (@(posedge clock_in) disable iff (!rstn_in) // R8
        fwd_fire && !is_custom && ce_in |=> time_hour_out == $past(rtc_hour_in) + 5'h01)
        else $error("preset forward step not one hour");
endmodule

// *** dv/dst_partner.sv ***
// far-side model: building-bus time source and expansion-module time sink
`timescale 1ns/1ps
module dst_partner (
    input wire logic clock_in,
    input wire logic rstn_in,
    input wire logic send_in,
    input wire logic [4:0] send_hour_in,
    input wire logic [5:0] send_minute_in,
    input wire logic tx_req_in,
    output logic bus_time_valid_out,
    output logic [4:0] bus_hour_out,
    output logic [5:0] bus_minute_out,
    output logic [7:0] tx_cnt_out
);
    // ------------------------------
    // bus time pulse and expansion receive count
    // ------------------------------
    logic valid_ff;
    logic [10:0] time_ff;
    logic [7:0] cnt_ff;
    always_ff @(posedge clock_in or negedge rstn_in) begin
        if (!rstn_in) begin
            valid_ff <= 1'b0;
            time_ff <= 11'h000;
            cnt_ff <= 8'h00;
        end else begin
            valid_ff <= send_in;
            // idle lines toggle so a stale time is never mistaken for a fresh one
            time_ff <= send_in ? {send_hour_in, send_minute_in} : ~time_ff;
            cnt_ff <= cnt_ff + {7'h00, tx_req_in};
        end
    end
    assign bus_time_valid_out = valid_ff;
    assign {bus_hour_out, bus_minute_out} = time_ff;
    assign tx_cnt_out = cnt_ff;
endmodule

// *** dv/dst_conv_bench.sv ***
// self-checking bench for the summertime conversion block
`timescale 1ns/1ps
module dst_conv_bench;
    import dst_pkg::*;
    logic clock_in = 1'b0;
    logic rstn_in = 1'b0;
    logic ce_in = 1'b1;
    logic powered_in = 1'b0;
    logic cfg_write_in = 1'b0, cfg_dst_en_in = 1'b0, cfg_sync_en_in = 1'b0;
    dst_sched_t cfg_sched_in = europe_schedule;
    logic [3:0] cfg_start_month_in = 4'h1, cfg_end_month_in = 4'h1, rtc_month_in = 4'h1;
    logic [4:0] cfg_start_day_in = 5'h01, cfg_end_day_in = 5'h01, rtc_day_in = 5'h01;
    logic [4:0] rtc_hour_in = 5'h00, bus_hour_in, time_hour_out, send_hour = 5'h00;
    logic [5:0] rtc_minute_in = 6'h00, bus_minute_in, time_minute_out, send_minute = 6'h00;
    logic [7:0] cfg_offset_in = 8'h00, tx_cnt, exp_tx = 8'h00;
    logic [2:0] rtc_wday_in = 3'h0;
    logic rtc_minute_tick_in = 1'b0, manual_set_in = 1'b0, send = 1'b0;
    logic bus_time_valid_in, rtc_load_out, tx_req_out, summer_out, cfg_reject_out;
    int error_cnt = 0, num_checks = 0;
    // ------------------------------
    // schedule table: start month, day, hour, end month, day, hour
    // ------------------------------
    localparam logic [27:0] TBL [7] = '{
        {4'h3, 5'h1F, 5'h02, 4'hA, 5'h1F, 5'h03}, {4'h3, 5'h1F, 5'h01, 4'hA, 5'h1F, 5'h02},
        {4'h4, 5'h01, 5'h02, 4'hA, 5'h1F, 5'h02}, {4'h3, 5'h08, 5'h02, 4'hB, 5'h01, 5'h02},
        {4'hA, 5'h1F, 5'h02, 4'h3, 5'h1F, 5'h03}, {4'hA, 5'h01, 5'h02, 4'h3, 5'h1F, 5'h03},
        {4'hA, 5'h01, 5'h02, 4'h3, 5'h0F, 5'h03}};
    localparam logic [27:0] CUS = {4'h3, 5'h1F, 5'h02, 4'hB, 5'h01, 5'h03};
    always #12.5 clock_in = ~clock_in;
    dst_conv dut (.clock_in, .rstn_in, .ce_in, .powered_in, .cfg_write_in, .cfg_dst_en_in,
        .cfg_sync_en_in, .cfg_sched_in, .cfg_start_month_in, .cfg_start_day_in,
        .cfg_end_month_in, .cfg_end_day_in, .cfg_offset_in, .rtc_month_in, .rtc_day_in,
        .rtc_wday_in, .rtc_hour_in, .rtc_minute_in, .rtc_minute_tick_in, .manual_set_in,
        .bus_time_valid_in, .bus_hour_in, .bus_minute_in, .rtc_load_out, .tx_req_out,
        .time_hour_out, .time_minute_out, .summer_out, .cfg_reject_out);
    dst_partner model (.clock_in, .rstn_in, .send_in(send), .send_hour_in(send_hour),
        .send_minute_in(send_minute), .tx_req_in(tx_req_out),
        .bus_time_valid_out(bus_time_valid_in), .bus_hour_out(bus_hour_in),
        .bus_minute_out(bus_minute_in), .tx_cnt_out(tx_cnt));
    // ------------------------------
    // access tasks
    // ------------------------------
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic wrap_up();
        $display("checks=%0d errors=%0d", num_checks, error_cnt);
        if (error_cnt == 0 && num_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic cfg(input logic [2:0] s, input logic en, input logic sy,
            input logic [27:0] d, input logic [7:0] off, input logic xrej);
        @(negedge clock_in);
        cfg_sched_in = dst_sched_t'(s);
        cfg_dst_en_in = en;
        cfg_sync_en_in = sy;
        {cfg_start_month_in, cfg_start_day_in} = d[27:19];
        {cfg_end_month_in, cfg_end_day_in} = d[13:5];
        cfg_offset_in = off;
        cfg_write_in = 1'b1;
        @(negedge clock_in);
        cfg_write_in = 1'b0;
        check(8'(cfg_reject_out), 8'(xrej));
    endtask
    task automatic tick(input logic [3:0] mo, input logic [4:0] dy, input logic [2:0] wd,
            input logic [4:0] hr);
        @(negedge clock_in);
        rtc_month_in = mo;
        rtc_day_in = dy;
        rtc_wday_in = wd;
        rtc_hour_in = hr;
        rtc_minute_in = 6'h00;
        rtc_minute_tick_in = 1'b1;
        @(negedge clock_in);
        rtc_minute_tick_in = 1'b0;
    endtask
    task automatic send_bus(input logic [4:0] h, input logic [5:0] m);
        @(negedge clock_in);
        send = 1'b1;
        send_hour = h;
        send_minute = m;
        @(negedge clock_in);
        send = 1'b0;
    endtask
    // bounded look for load and send; time captured while either stands
    task automatic watch(input logic xl, input logic xt, input logic [4:0] xh,
            input logic [5:0] xm);
        logic l, t;
        logic [4:0] h;
        logic [5:0] m;
        l = 1'b0;
        t = 1'b0;
        h = 5'h00;
        m = 6'h00;
        repeat (8) begin
            @(negedge clock_in);
            if (rtc_load_out === 1'b1 || tx_req_out === 1'b1) begin
                h = time_hour_out;
                m = time_minute_out;
            end
            l = l | (rtc_load_out === 1'b1);
            t = t | (tx_req_out === 1'b1);
        end
        check(8'(l), 8'(xl));
        check(8'(t), 8'(xt));
        if (xl | xt) begin
            check(8'(h), 8'(xh));
            check(8'(m), 8'(xm));
        end
        exp_tx = exp_tx + 8'(xt);
    endtask
    // ------------------------------
    // main sequence
    // ------------------------------
    initial begin
        repeat (16) @(negedge clock_in);
        rstn_in = 1'b1;
        repeat (2) @(negedge clock_in);
        check(8'(summer_out), 8'h00);
        send_bus(5'h0A, 6'h15);
        watch(1'b0, 1'b0, 5'h00, 6'h00);
        powered_in = 1'b1;
        watch(1'b0, 1'b1, 5'h00, 6'h00);
        for (int i = 0; i < 7; i++) begin
            cfg(3'(i), 1'b1, 1'b0, TBL[i], 8'h00, 1'b0);
            tick(TBL[i][27:24], TBL[i][23:19], 3'h0, TBL[i][18:14]);
            watch(1'b1, 1'b1, TBL[i][18:14] + 5'h01, 6'h00);
            check(8'(summer_out), 8'h01);
            tick(TBL[i][13:10], TBL[i][9:5], 3'h0, TBL[i][4:0]);
            watch(1'b1, 1'b1, TBL[i][4:0] - 5'h01, 6'h00);
            check(8'(summer_out), 8'h00);
            // repeated hour after going back must not shift again
            tick(TBL[i][13:10], TBL[i][9:5], 3'h0, TBL[i][4:0]);
            watch(1'b0, 1'b1, TBL[i][4:0], 6'h00);
        end
        cfg(3'h0, 1'b1, 1'b0, TBL[0], 8'h00, 1'b0);
        tick(4'h3, 5'h18, 3'h0, 5'h02);
        watch(1'b0, 1'b1, 5'h02, 6'h00);
        tick(4'h3, 5'h1F, 3'h1, 5'h02);
        watch(1'b0, 1'b1, 5'h02, 6'h00);
        powered_in = 1'b0;
        repeat (4) @(negedge clock_in);
        tick(4'h3, 5'h1F, 3'h0, 5'h02);
        watch(1'b0, 1'b0, 5'h00, 6'h00);
        powered_in = 1'b1;
        watch(1'b0, 1'b1, 5'h02, 6'h00);
        cfg(3'h7, 1'b1, 1'b0, CUS, 8'hB4, 1'b0);
        cfg(3'h7, 1'b1, 1'b0, CUS, 8'hB5, 1'b1);
        tick(4'h3, 5'h1F, 3'h0, 5'h02);
        watch(1'b1, 1'b1, 5'h05, 6'h00);
        tick(4'hB, 5'h01, 3'h0, 5'h03);
        watch(1'b1, 1'b1, 5'h00, 6'h00);
        tick(4'h3, 5'h1F, 3'h0, 5'h02);
        watch(1'b1, 1'b1, 5'h05, 6'h00);
        cfg(3'h7, 1'b0, 1'b0, CUS, 8'hB4, 1'b0);
        @(negedge clock_in);
        check(8'(summer_out), 8'h00);
        tick(4'hB, 5'h01, 3'h0, 5'h03);
        watch(1'b0, 1'b1, 5'h03, 6'h00);
        // sync only enabled because the model holds a bus module
        cfg(3'h0, 1'b0, 1'b1, CUS, 8'h00, 1'b0);
        send_bus(5'h0A, 6'h15);
        watch(1'b1, 1'b1, 5'h0A, 6'h15);
        @(negedge clock_in);
        rtc_hour_in = 5'h07;
        rtc_minute_in = 6'h21;
        manual_set_in = 1'b1;
        @(negedge clock_in);
        manual_set_in = 1'b0;
        watch(1'b0, 1'b1, 5'h07, 6'h21);
        // frozen clock enable holds a pending send until released
        @(negedge clock_in);
        manual_set_in = 1'b1;
        @(negedge clock_in);
        manual_set_in = 1'b0;
        ce_in = 1'b0;
        watch(1'b0, 1'b0, 5'h00, 6'h00);
        ce_in = 1'b1;
        watch(1'b0, 1'b1, 5'h07, 6'h21);
        check(tx_cnt, exp_tx);
        wrap_up();
    end
endmodule
